// [design/pmcs_top.sv]
// Clock source, low-voltage detect and power-mode control block
`timescale 1ns/1ps
`default_nettype none
module pmcs_top #(
  parameter int STAB_CYC = 4
) (
  input  wire logic       clock,
  input  wire logic       rst_n,
  input  wire logic [1:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  input  wire logic [7:0] code_option_w1,
  input  wire logic [3:0] vdd_above,
  input  wire logic       sleep_instruction,
  input  wire logic       wake_event,
  input  wire logic       ext_pin_wake,
  input  wire logic       osc_is_crystal,
  input  wire logic       osc_stable,
  output logic            irq,
  output logic            fetch_enable,
  output logic            idle_mode,
  output logic            sleep_mode,
  output logic            cpu_clk_sel_main,
  output logic            main_osc_enable,
  output logic            counter_clk_sel_main,
  output logic      [1:0] rc_freq_sel,
  output logic            ext_pin_wake_enable,
  output logic            low_volt_state_n
);
  // The floor must fit the shared counter and leave at least one cycle
  if (STAB_CYC < 1 || STAB_CYC >= (1 << pmcs_pkg::CNT_W))
  begin : g_stab_cyc_bad
    $error("STAB_CYC out of range");
  end

  logic [7:0] lvd_r;
  logic [7:0] sys_r;
  logic [7:0] stat_r;
  logic [7:0] mask_r;
  logic       state_n_r;
  logic       boot_r;
  logic       xtal_wake_r;
  logic [pmcs_pkg::CNT_W-1:0] cnt_r;
  pmcs_pkg::pmcs_state_t st_r;
  logic       wr_lvd;
  logic       wr_sys;
  logic       rc_change;
  logic       state_n_nxt;
  logic [7:0] evt;
  logic       wake_req;
  logic       cnt_zero;
  logic       sleep_go;
  logic       wake_go;
  logic       stab_done;

  function automatic logic [pmcs_pkg::CNT_W-1:0] rc_settle(
    input logic [1:0] sel
  );
    unique case (sel)
      pmcs_pkg::RC_4M:  rc_settle = pmcs_pkg::CNT_W'(pmcs_pkg::RC_SET_4M_CYC);
      pmcs_pkg::RC_16M: rc_settle = pmcs_pkg::CNT_W'(pmcs_pkg::RC_SET_16M_CYC);
      pmcs_pkg::RC_8M:  rc_settle = pmcs_pkg::CNT_W'(pmcs_pkg::RC_SET_8M_CYC);
      default:          rc_settle = pmcs_pkg::CNT_W'(pmcs_pkg::RC_SET_1M_CYC);
    endcase
  endfunction

  assign wr_lvd = reg_wr && (reg_addr == pmcs_pkg::ADDR_LVD);
  assign wr_sys = reg_wr && (reg_addr == pmcs_pkg::ADDR_SYS);
  assign rc_change = wr_sys && (reg_wdata[pmcs_pkg::SYS_RC_HI:pmcs_pkg::SYS_RC_LO]
                     != sys_r[pmcs_pkg::SYS_RC_HI:pmcs_pkg::SYS_RC_LO]);

  // Threshold compare; vdd_above[i] is high when supply exceeds level code i
  always_comb
  begin
    if (!lvd_r[pmcs_pkg::LVD_EN_BIT])
      state_n_nxt = 1'b1;
    else
      state_n_nxt = vdd_above[lvd_r[pmcs_pkg::LVD_LVL_HI:pmcs_pkg::LVD_LVL_LO]];
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      lvd_r <= pmcs_pkg::LVD_RST;
    else if (wr_lvd)
      lvd_r <= reg_wdata & pmcs_pkg::LVD_MASK;
  end

  // Strap of the RC select is taken on the first clock after release
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sys_r  <= pmcs_pkg::SYS_RST;
      boot_r <= 1'b1;
    end
    else if (boot_r)
    begin
      boot_r <= 1'b0;
      sys_r[pmcs_pkg::SYS_RC_HI] <= code_option_w1[pmcs_pkg::OPT_RC_HI];
      sys_r[pmcs_pkg::SYS_RC_LO] <= code_option_w1[pmcs_pkg::OPT_RC_LO];
    end
    else if (wr_sys)
      sys_r <= reg_wdata & pmcs_pkg::SYS_MASK;
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      state_n_r <= 1'b1;
    else
      state_n_r <= state_n_nxt;
  end

  // Event vector: low-voltage crossing and end of a COUNT (RC settle or wake count)
  always_comb
  begin
    evt = 8'h00;
    evt[pmcs_pkg::STAT_LVD_BIT] = (state_n_nxt != state_n_r);
    evt[pmcs_pkg::STAT_RC_BIT]  = (st_r == pmcs_pkg::PMCS_COUNT) && (cnt_r == '0);
  end

  // Set beats a same-cycle write-one-to-clear
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      stat_r <= 8'h00;
    else if (reg_wr && reg_addr == pmcs_pkg::ADDR_STAT)
      stat_r <= ((stat_r & ~reg_wdata) | evt) & pmcs_pkg::EVT_MASK;
    else
      stat_r <= stat_r | evt;
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      mask_r <= 8'h00;
    else if (reg_wr && reg_addr == pmcs_pkg::ADDR_MASK)
      mask_r <= reg_wdata & pmcs_pkg::EVT_MASK;
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      irq <= 1'b0;
    else
      irq <= ((stat_r[pmcs_pkg::STAT_LVD_BIT] & lvd_r[pmcs_pkg::LVD_IE_BIT]
              & mask_r[pmcs_pkg::STAT_LVD_BIT])
             | (stat_r[pmcs_pkg::STAT_RC_BIT] & mask_r[pmcs_pkg::STAT_RC_BIT]));
  end

  // Sequencer qualifiers shared by the state, counter and mode registers
  assign wake_req  = wake_event
                     || (ext_pin_wake && lvd_r[pmcs_pkg::LVD_WAKE_BIT]);
  assign cnt_zero  = (cnt_r == '0);
  assign sleep_go  = (st_r == pmcs_pkg::PMCS_RUN) && !rc_change
                     && sleep_instruction;
  assign wake_go   = (st_r == pmcs_pkg::PMCS_LOWPWR) && wake_req;
  assign stab_done = (st_r == pmcs_pkg::PMCS_STAB) && cnt_zero && osc_stable;

  // Power-mode sequencer; a frequency change reuses the counting state
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      st_r <= pmcs_pkg::PMCS_RUN;
    else
    begin
      unique case (st_r)
        pmcs_pkg::PMCS_RUN:
        begin
          if (rc_change)
            st_r <= pmcs_pkg::PMCS_COUNT;
          else if (sleep_instruction)
            st_r <= pmcs_pkg::PMCS_LOWPWR;
        end
        pmcs_pkg::PMCS_LOWPWR:
        begin
          if (wake_req)
            st_r <= pmcs_pkg::PMCS_STAB;
        end
        pmcs_pkg::PMCS_STAB:
        begin
          if (cnt_zero && osc_stable)
            st_r <= pmcs_pkg::PMCS_COUNT;
        end
        pmcs_pkg::PMCS_COUNT:
        begin
          if (cnt_zero)
            st_r <= pmcs_pkg::PMCS_RUN;
        end
        default:
          st_r <= pmcs_pkg::PMCS_RUN;
      endcase
    end
  end

  // One down-counter serves the floor, the wake count and the RC settle
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      cnt_r <= '0;
    else if (st_r == pmcs_pkg::PMCS_RUN && rc_change)
      cnt_r <= rc_settle(
        reg_wdata[pmcs_pkg::SYS_RC_HI:pmcs_pkg::SYS_RC_LO]);
    else if (wake_go)
      cnt_r <= pmcs_pkg::CNT_W'(STAB_CYC);
    else if (stab_done)
      cnt_r <= xtal_wake_r ? pmcs_pkg::CNT_W'(pmcs_pkg::WAKE_XTAL_CLK - 1)
                           : pmcs_pkg::CNT_W'(pmcs_pkg::WAKE_OTHER_CLK - 1);
    else if ((st_r == pmcs_pkg::PMCS_STAB || st_r == pmcs_pkg::PMCS_COUNT)
             && !cnt_zero)
      cnt_r <= cnt_r - 1'b1;
  end

  // Long count only when the crystal will clock the CPU after waking
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      xtal_wake_r <= 1'b0;
    else if (wake_go)
      xtal_wake_r <= osc_is_crystal & sys_r[pmcs_pkg::SYS_CPU_BIT];
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      idle_mode  <= 1'b0;
      sleep_mode <= 1'b0;
    end
    else if (sleep_go)
    begin
      idle_mode  <= sys_r[pmcs_pkg::SYS_IDLE_BIT];
      sleep_mode <= ~sys_r[pmcs_pkg::SYS_IDLE_BIT];
    end
    else if (wake_go)
    begin
      idle_mode  <= 1'b0;
      sleep_mode <= 1'b0;
    end
  end

  assign fetch_enable = (st_r == pmcs_pkg::PMCS_RUN) && !rc_change;

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      reg_rdata <= 8'h00;
    else if (reg_rd)
    begin
      unique case (reg_addr)
        pmcs_pkg::ADDR_LVD:  reg_rdata <= lvd_r;
        pmcs_pkg::ADDR_SYS:  reg_rdata <= sys_r;
        pmcs_pkg::ADDR_STAT: reg_rdata <= stat_r;
        pmcs_pkg::ADDR_MASK: reg_rdata <= mask_r;
      endcase
    end
    else
      reg_rdata <= 8'h00;
  end

  assign cpu_clk_sel_main     = sys_r[pmcs_pkg::SYS_CPU_BIT];
  assign main_osc_enable      = sys_r[pmcs_pkg::SYS_CPU_BIT];
  assign counter_clk_sel_main = sys_r[pmcs_pkg::SYS_TMR_BIT];
  assign rc_freq_sel          = sys_r[pmcs_pkg::SYS_RC_HI:pmcs_pkg::SYS_RC_LO];
  assign ext_pin_wake_enable  = lvd_r[pmcs_pkg::LVD_WAKE_BIT];
  assign low_volt_state_n     = state_n_r;
endmodule
`default_nettype wire

// [design/pmcs_pkg.sv]
// Package: register map, field layout and timing constants for clock/power control
package pmcs_pkg;
  localparam logic [1:0] ADDR_LVD   = 2'h0;
  localparam logic [1:0] ADDR_SYS   = 2'h1;
  localparam logic [1:0] ADDR_STAT  = 2'h2;
  localparam logic [1:0] ADDR_MASK  = 2'h3;
  localparam int LVD_IE_BIT   = 7;
  localparam int LVD_EN_BIT   = 6;
  localparam int LVD_LVL_HI   = 5;
  localparam int LVD_LVL_LO   = 4;
  localparam int LVD_WAKE_BIT = 0;
  localparam int SYS_TMR_BIT  = 6;
  localparam int SYS_CPU_BIT  = 5;
  localparam int SYS_IDLE_BIT = 4;
  localparam int SYS_RC_HI    = 1;
  localparam int SYS_RC_LO    = 0;
  localparam int OPT_RC_HI    = 6;
  localparam int OPT_RC_LO    = 5;
  localparam int STAT_LVD_BIT = 0;
  localparam int STAT_RC_BIT  = 1;
  localparam logic [7:0] LVD_RST  = 8'h00;
  localparam logic [7:0] SYS_RST  = 8'h60;
  localparam logic [7:0] LVD_MASK = 8'hF1;
  localparam logic [7:0] SYS_MASK = 8'h73;
  localparam logic [7:0] EVT_MASK = 8'h03;
  // Threshold codes for the comparator bank (index into vdd_above input)
  localparam logic [1:0] LVL_2V2 = 2'b11;
  localparam logic [1:0] LVL_3V3 = 2'b10;
  localparam logic [1:0] LVL_4V0 = 2'b01;
  localparam logic [1:0] LVL_4V5 = 2'b00;
  localparam logic [1:0] RC_4M  = 2'b11;
  localparam logic [1:0] RC_16M = 2'b10;
  localparam logic [1:0] RC_8M  = 2'b01;
  localparam logic [1:0] RC_1M  = 2'b00;
  localparam int WAKE_XTAL_CLK  = 510;
  localparam int WAKE_OTHER_CLK = 8;
  localparam int CLK_MHZ = 10;
  // Settling times in ns, worst row of each target frequency
  localparam int RC_SET_4M_NS  = 5000;
  localparam int RC_SET_16M_NS = 1500;
  localparam int RC_SET_8M_NS  = 3000;
  localparam int RC_SET_1M_NS  = 24000;
  localparam int CLK_PERIOD_NS = 1000 / CLK_MHZ;
  // Least time: round up, at least one cycle
  localparam int RC_SET_4M_CYC  = (RC_SET_4M_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RC_SET_16M_CYC = (RC_SET_16M_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RC_SET_8M_CYC  = (RC_SET_8M_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RC_SET_1M_CYC  = (RC_SET_1M_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 10;
  typedef enum logic [3:0] {
    PMCS_RUN    = 4'b0001,
    PMCS_LOWPWR = 4'b0010,
    PMCS_STAB   = 4'b0100,
    PMCS_COUNT  = 4'b1000
  } pmcs_state_t;
endpackage

// [dv/pmcs_checker.sv]
// Port-level assertions for the clock and power-mode control block
`timescale 1ns/1ps
`default_nettype none
module pmcs_checker (
  input wire logic       clock,
  input wire logic       rst_n,
  input wire logic [1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       sleep_instruction,
  input wire logic       fetch_enable,
  input wire logic       idle_mode,
  input wire logic       sleep_mode,
  input wire logic       cpu_clk_sel_main,
  input wire logic       main_osc_enable,
  input wire logic       counter_clk_sel_main,
  input wire logic [1:0] rc_freq_sel,
  input wire logic       low_volt_state_n
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  logic wr_lvd;
  logic wr_sys;
  logic run;
  assign wr_lvd = reg_wr && reg_addr == pmcs_pkg::ADDR_LVD;
  assign wr_sys = reg_wr && reg_addr == pmcs_pkg::ADDR_SYS;
  assign run    = !sleep_mode && !idle_mode;
  AST_LVD_RSVD: assert property ($past(reg_rd) &&
    $past(reg_addr) == pmcs_pkg::ADDR_LVD |-> reg_rdata[3:1] == 3'h0)
    else $error("reserved low-voltage bits read nonzero");
  AST_SYS_RSVD: assert property ($past(reg_rd) &&
    $past(reg_addr) == pmcs_pkg::ADDR_SYS |->
    {reg_rdata[7], reg_rdata[3:2]} == 3'h0)
    else $error("reserved system bits read nonzero");
  AST_OSC_STOP: assert property (main_osc_enable == cpu_clk_sel_main)
    else $error("main oscillator enable differs from cpu source");
  AST_DET_OFF: assert property (wr_lvd && !reg_wdata[6] ##1 !wr_lvd
    |=> low_volt_state_n) else $error("disabled detector reads low");
  AST_CNT_SRC: assert property (wr_sys |=>
    counter_clk_sel_main == $past(reg_wdata[6]))
    else $error("counter clock source not updated");
  AST_SLEEP_IN: assert property (sleep_instruction && fetch_enable && run
    |=> sleep_mode ^ idle_mode) else $error("low power not entered");
  AST_NO_FETCH: assert property (!run |-> !fetch_enable)
    else $error("fetch enabled in low power");
  AST_RC_HOLD: assert property (wr_sys && $past(fetch_enable) &&
    run && reg_wdata[1:0] != rc_freq_sel |=> !fetch_enable [*8])
    else $error("rc change hold too short");
  COV_SLEEP: cover property (sleep_instruction ##1 sleep_mode);
  COV_IDLE: cover property (sleep_instruction ##1 idle_mode);
  COV_HOLD: cover property (!fetch_enable ##1 fetch_enable);
endmodule
bind pmcs_top pmcs_checker chk_u (
  .clock(clock), .rst_n(rst_n), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .sleep_instruction(sleep_instruction),
  .fetch_enable(fetch_enable), .idle_mode(idle_mode),
  .sleep_mode(sleep_mode), .cpu_clk_sel_main(cpu_clk_sel_main),
  .main_osc_enable(main_osc_enable), .rc_freq_sel(rc_freq_sel),
  .counter_clk_sel_main(counter_clk_sel_main),
  .low_volt_state_n(low_volt_state_n));
`default_nettype wire

// [dv/pmcs_top_test.sv]
// Self-checking bench for the clock and power-mode control block
`timescale 1ns/1ps
`default_nettype none
module pmcs_top_test;
  localparam int STAB = 2;
  logic       clock = 1'b0;
  logic       rst_n, reg_wr, reg_rd, sleep_instruction, wake_event;
  logic       ext_pin_wake, osc_is_crystal, osc_stable, irq, fetch_enable;
  logic       idle_mode, sleep_mode, cpu_clk_sel_main, main_osc_enable;
  logic       counter_clk_sel_main, ext_pin_wake_enable, low_volt_state_n;
  logic [1:0] reg_addr, rc_freq_sel;
  logic [7:0] reg_wdata, reg_rdata, code_option_w1;
  logic [3:0] vdd_above;
  int         errors, num_checks, n;
  pmcs_top #(.STAB_CYC(STAB)) dut_u (.clock, .rst_n, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .code_option_w1, .vdd_above,
    .sleep_instruction, .wake_event, .ext_pin_wake, .osc_is_crystal,
    .osc_stable, .irq, .fetch_enable, .idle_mode, .sleep_mode,
    .cpu_clk_sel_main, .main_osc_enable, .counter_clk_sel_main,
    .rc_freq_sel, .ext_pin_wake_enable, .low_volt_state_n);
  always #50 clock = ~clock;
  task automatic chk(input logic ok, input string m);
    num_checks++;
    if (ok !== 1'b1)
    begin
      errors++;
      $display("CHECK FAILED at %0t: %s", $time, m);
    end
  endtask
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clock);
    reg_wr    <= 1'b0;
  endtask
  task automatic rd(input logic [1:0] a, input logic [7:0] e);
    @(posedge clock);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clock);
    reg_rd   <= 1'b0;
    #1 chk(reg_rdata === e, "read data");
  endtask
  // Bounded wait for fetch release; n counts edges waited
  task automatic wait_run(input int lo, input int hi, input string m);
    n = 0;
    #1;
    while (fetch_enable !== 1'b1 && n < 3000)
    begin
      @(posedge clock);
      #1 n++;
    end
    chk(n >= lo && n <= hi, m);
  endtask
  task automatic slp;
    @(posedge clock);
    sleep_instruction <= 1'b1;
    @(posedge clock);
    sleep_instruction <= 1'b0;
    #1;
  endtask
  task automatic t_reset;
    rd(pmcs_pkg::ADDR_SYS, 8'h62);
    rd(pmcs_pkg::ADDR_LVD, 8'h00);
    chk(low_volt_state_n === 1'b1, "state at reset");
    $display("test reset done");
  endtask
  task automatic t_regs;
    wr(pmcs_pkg::ADDR_LVD, 8'hFF);
    rd(pmcs_pkg::ADDR_LVD, 8'hF1);
    chk(ext_pin_wake_enable === 1'b1, "wake enable");
    wr(pmcs_pkg::ADDR_SYS, 8'hDE);
    rd(pmcs_pkg::ADDR_SYS, 8'h52);
    chk(!main_osc_enable && !cpu_clk_sel_main, "sub clock");
    wr(pmcs_pkg::ADDR_SYS, 8'h22);
    #1 chk(counter_clk_sel_main === 1'b0, "counter src");
    $display("test regs done");
  endtask
  task automatic t_detect;
    vdd_above <= 4'b1100;
    for (int l = 0; l < 4; l++)
    begin
      wr(pmcs_pkg::ADDR_LVD, 8'h40 | 8'(l << 4));
      @(posedge clock);
      #1 chk(low_volt_state_n === vdd_above[l], "level");
    end
    wr(pmcs_pkg::ADDR_MASK, 8'h01);
    wr(pmcs_pkg::ADDR_STAT, 8'h03);
    wr(pmcs_pkg::ADDR_LVD, 8'hC0);
    repeat (3) @(posedge clock);
    chk(irq === 1'b1, "irq on crossing");
    rd(pmcs_pkg::ADDR_STAT, 8'h01);
    wr(pmcs_pkg::ADDR_STAT, 8'h01);
    wr(pmcs_pkg::ADDR_LVD, 8'h40);
    vdd_above <= 4'b1111;
    repeat (3) @(posedge clock);
    chk(irq === 1'b0, "irq gated off");
    rd(pmcs_pkg::ADDR_STAT, 8'h01);
    wr(pmcs_pkg::ADDR_LVD, 8'h00);
    vdd_above <= 4'b0000;
    repeat (3) @(posedge clock);
    chk(low_volt_state_n === 1'b1, "disabled state");
    $display("test detect done");
  endtask
  task automatic t_rc;
    logic [1:0] c;
    int         cyc;
    wr(pmcs_pkg::ADDR_STAT, 8'h03);
    for (int i = 0; i < 4; i++)
    begin
      c = 2'(i) ^ 2'b11;
      cyc = c == pmcs_pkg::RC_4M  ? pmcs_pkg::RC_SET_4M_CYC  :
            c == pmcs_pkg::RC_16M ? pmcs_pkg::RC_SET_16M_CYC :
            c == pmcs_pkg::RC_8M  ? pmcs_pkg::RC_SET_8M_CYC  :
            pmcs_pkg::RC_SET_1M_CYC;
      wr(pmcs_pkg::ADDR_SYS, {6'h08, c});
      wait_run(cyc, cyc + 2, "rc hold");
      chk(rc_freq_sel === c, "rc select");
    end
    rd(pmcs_pkg::ADDR_STAT, 8'h02);
    wr(pmcs_pkg::ADDR_MASK, 8'h02);
    repeat (2) @(posedge clock);
    chk(irq === 1'b1, "settle irq unmasked");
    wr(pmcs_pkg::ADDR_STAT, 8'h03);
    $display("test rc done");
  endtask
  task automatic t_wake;
    osc_is_crystal <= 1'b1;
    wr(pmcs_pkg::ADDR_SYS, 8'h20);
    slp();
    chk(sleep_mode && !idle_mode && !fetch_enable, "sleep");
    @(posedge clock);
    wake_event <= 1'b1;
    @(posedge clock);
    wake_event <= 1'b0;
    wait_run(STAB + 510, STAB + 514, "crystal wake");
    osc_is_crystal <= 1'b0;
    wr(pmcs_pkg::ADDR_SYS, 8'h30);
    slp();
    chk(idle_mode && !sleep_mode, "idle");
    ext_pin_wake <= 1'b1;
    repeat (4) @(posedge clock);
    chk(idle_mode === 1'b1, "pin wake masked");
    osc_stable <= 1'b0;
    wr(pmcs_pkg::ADDR_LVD, 8'h01);
    repeat (STAB + 4) @(posedge clock);
    chk(!fetch_enable && !idle_mode, "osc not stable");
    osc_stable <= 1'b1;
    wait_run(9, 11, "short wake");
    ext_pin_wake <= 1'b0;
    $display("test wake done");
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial
  begin
    {rst_n, reg_wr, reg_rd, sleep_instruction, wake_event} = '0;
    {ext_pin_wake, osc_is_crystal, reg_addr, reg_wdata} = '0;
    osc_stable = 1'b1;
    vdd_above = 4'hF;
    code_option_w1 = 8'h40;
    repeat (4) @(posedge clock);
    rst_n <= 1'b1;
    repeat (2) @(posedge clock);
    t_reset();
    t_regs();
    t_detect();
    t_rc();
    t_wake();
    stop_test();
  end
  // Whole run is near 1000 cycles; a hang stops at 10000
  initial
  begin
    #1000000;
    errors++;
    stop_test();
  end
endmodule
`default_nettype wire
